// *** hdl/timer_setup_defs.vh ***
// register offsets, field positions, codes and reset values of the timer setup block
`ifndef TIMER_SETUP_DEFS_VH
`define TIMER_SETUP_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_PRESCALE   8'h00
`define OFS_STOP       8'h04
`define OFS_STOP_HI    8'h08
`define OFS_START      8'h0c
`define OFS_STATUS     8'h10
`define OFS_MODE_BASE  8'h20

// ****************************************
// reset values and write masks
// ****************************************
`define PRESCALE_RST   8'h00
`define MODE_RST       16'h0000
`define MODE_WMASK     16'h9fcf

// ****************************************
// field positions inside a channel mode word, the status word and the start word
// ****************************************
`define CLK_SEL_BIT    15
`define CNT_SRC_BIT    12
`define SPLIT_BIT      11
`define TRIG_HI        10
`define TRIG_LO        8
`define EDGE_HI        7
`define EDGE_LO        6
`define FUNC_HI        3
`define FUNC_LO        1
`define STS_RUN_LO     0
`define STS_RUN_HI_LO  8
`define STS_BAD_LO     16
`define STS_PIN_LO     24
`define START_HI_LO    4

// ****************************************
// prescaler counter width and codes
// ****************************************
`define PRESCALE_W     15
`define TRIG_SW        3'h0
`define TRIG_EDGE      3'h1
`define TRIG_BOTH      3'h2
`define TRIG_MASTER    3'h4
`define TRIG_MASTER_END 3'h6
`define EDGE_FALL      2'h0
`define EDGE_RISE      2'h1
`define EDGE_LOW_W     2'h2
`define EDGE_HIGH_W    2'h3
`define FN_INTERVAL    3'h0
`define FN_CAPTURE     3'h2
`define FN_EVENT       3'h3
`define FN_ONE_COUNT   3'h4
`define FN_CAP_ONE     3'h6

`endif

// *** hdl/timer_channel.v ***
// one timer channel: clock choice, edge detect, trigger routing and run flags
`timescale 1ns/10ps
`include "timer_setup_defs.vh"

module timer_channel #(
	parameter SPLIT_OK = 0
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire [15:0] mode,
	input  wire        tick_a,
	input  wire        tick_b,
	input  wire        pin_level,
	input  wire        sw_start,
	input  wire        sw_start_hi,
	input  wire        stop,
	input  wire        stop_hi,
	input  wire        master_irq,
	output reg         count_tick_q,
	output reg         start_trig_q,
	output reg         capture_trig_q,
	output reg         end_trig_q,
	output reg         running_q,
	output reg         running_hi_q,
	output reg         bad_q
);

	reg       prev_q;
	wire      rise;
	wire      fall;
	reg       st_e;
	reg       cap_e;
	reg       val_e;
	reg       start_c;
	reg       cap_c;
	reg       end_c;
	reg       bad_c;
	wire      op_tick;
	wire      src_tick;
	wire [2:0] func;
	wire      halves;

	assign rise = pin_level & ~prev_q;
	assign fall = ~pin_level & prev_q;
	assign func = mode[`FUNC_HI:`FUNC_LO];
	assign halves = (SPLIT_OK != 0) & mode[`SPLIT_BIT];
	assign op_tick = mode[`CLK_SEL_BIT] ? tick_b : tick_a;
	assign src_tick = mode[`CNT_SRC_BIT] ? val_e : op_tick;

	always @* begin
		case (mode[`EDGE_HI:`EDGE_LO])
		`EDGE_FALL: begin
			st_e = fall;
			cap_e = fall;
			val_e = fall;
		end
		`EDGE_RISE: begin
			st_e = rise;
			cap_e = rise;
			val_e = rise;
		end
		`EDGE_LOW_W: begin
			st_e = fall;
			cap_e = rise;
			val_e = rise | fall;
		end
		default: begin
			st_e = rise;
			cap_e = fall;
			val_e = rise | fall;
		end
		endcase
	end

	// software start stays valid under every trigger source
	always @* begin
		start_c = sw_start;
		cap_c = 1'b0;
		end_c = 1'b0;
		bad_c = 1'b0;
		case (mode[`TRIG_HI:`TRIG_LO])
		`TRIG_SW: start_c = sw_start;
		`TRIG_EDGE: begin
			start_c = sw_start | st_e;
			cap_c = cap_e;
		end
		`TRIG_BOTH: begin
			start_c = sw_start | rise | fall;
			cap_c = rise | fall;
		end
		`TRIG_MASTER: start_c = sw_start | (master_irq & (func == `FN_ONE_COUNT));
		`TRIG_MASTER_END: begin
			start_c = sw_start | master_irq;
			end_c = cap_e;
		end
		default: bad_c = 1'b1;
		endcase
		case (func)
		`FN_INTERVAL, `FN_CAPTURE, `FN_EVENT, `FN_ONE_COUNT, `FN_CAP_ONE: bad_c = bad_c;
		default: bad_c = 1'b1;
		endcase
	end

	// stop beats a start written in the same cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_q <= 1'b0;
			count_tick_q <= 1'b0;
			start_trig_q <= 1'b0;
			capture_trig_q <= 1'b0;
			end_trig_q <= 1'b0;
			running_q <= 1'b0;
			running_hi_q <= 1'b0;
			bad_q <= 1'b0;
		end else begin
			prev_q <= pin_level;
			running_q <= ~stop & (running_q | sw_start);
			running_hi_q <= halves & ~stop_hi & (running_hi_q | sw_start_hi);
			count_tick_q <= src_tick & running_q & ~stop;
			start_trig_q <= start_c & ~stop & (running_q | sw_start);
			capture_trig_q <= cap_c & running_q & ~stop;
			end_trig_q <= end_c & running_q & ~stop;
			bad_q <= bad_c;
		end
	end

endmodule // timer_channel

// *** hdl/timer_setup.v ***
// timer clock prescaler and channel setup front end with an AHB-Lite register slave
//
// How it works
// - two op clocks, each system clock divided by 2^m from its nibble.
// - clock-select bit 7 of high byte picks op clock a or b.
// - count-source bit 4 picks op clock or valid input pin edges.
// - on channels 1 and 3 bit 3 splits into two 8-bit timers.
// - trigger code 000 accepts only software start.
// - trigger code 001 uses selected pin edge as start and capture.
// - trigger code 010 uses both pin edges as start and capture.
// - trigger code 100 starts a one-shot/PWM slave on master interrupt.
// - code 110 starts on master interrupt, ends on own pin edge; others prohibited.
// - edge field picks falling, rising, or both with start/capture split.
// - two channels in small variant, four in large, each configured alone.
// - function field selects interval, capture, event, one-count, capture one-count.
// - writing one to a stop bit clears running flag and halts counting.
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`include "timer_setup_defs.vh"

module timer_setup #(
	parameter NUM_CH = 4
) (
	input  wire                hclk,
	input  wire                hresetn,
	input  wire                hsel,
	input  wire [31:0]         haddr,
	input  wire [1:0]          htrans,
	input  wire                hwrite,
	input  wire [2:0]          hsize,
	input  wire [31:0]         hwdata,
	input  wire                hready,
	output wire [31:0]         hrdata,
	output wire                hreadyout,
	output wire                hresp,
	input  wire [NUM_CH-1:0]   timer_input_pin,
	input  wire [NUM_CH-1:0]   master_channel_irq,
	output wire                op_clock_a,
	output wire                op_clock_b,
	output wire [NUM_CH-1:0]   channel_count_clock,
	output wire [NUM_CH-1:0]   start_trigger,
	output wire [NUM_CH-1:0]   capture_trigger,
	output wire [NUM_CH-1:0]   end_trigger,
	output wire [NUM_CH-1:0]   channel_running_flag,
	output wire [NUM_CH-1:0]   upper_running_flag,
	output wire [NUM_CH-1:0]   eight_bit_halves,
	output wire [3*NUM_CH-1:0] channel_function_field
);

	// ****************************************
	// declarations
	// ****************************************
	reg  [31:0]             hrdata_q;
	reg                     hreadyout_q;
	reg                     hresp_q;
	reg  [31:0]             rdata_d;
	reg  [7:0]              addr_q;
	reg                     wr_pend_q;
	reg                     rd_pend_q;
	wire                    accept;
	wire                    commit;
	reg  [7:0]              presc_q;
	reg  [15:0]             mode_q [0:NUM_CH-1];
	reg  [`PRESCALE_W-1:0]  div_cnt_q;
	wire [15:0]             mask_a;
	wire [15:0]             mask_b;
	reg                     op_a_q;
	reg                     op_b_q;
	reg  [NUM_CH-1:0]       sync1_q;
	reg  [NUM_CH-1:0]       sync2_q;
	reg  [NUM_CH-1:0]       sync3_q;
	reg  [NUM_CH-1:0]       pin_lvl_q;
	wire [NUM_CH-1:0]       pin_lvl_d;
	wire                    wr_stop;
	wire                    wr_stop_hi;
	wire                    wr_start;
	wire [NUM_CH-1:0]       run;
	wire [NUM_CH-1:0]       run_hi;
	wire [NUM_CH-1:0]       bad;
	reg  [NUM_CH-1:0]       halves_q;
	reg  [3*NUM_CH-1:0]     func_q;
	integer                 k;
	integer                 j;
	integer                 m;

	// ****************************************
	// bus outputs
	// ****************************************
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;

	// ****************************************
	// AHB-Lite address and data phases
	// ****************************************
	// reads take one wait state so that a write just before is seen
	assign accept = hsel & htrans[1] & hready;
	assign commit = wr_pend_q;
	assign wr_stop = commit & (addr_q == `OFS_STOP);
	assign wr_stop_hi = commit & (addr_q == `OFS_STOP_HI);
	assign wr_start = commit & (addr_q == `OFS_START);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 8'h00;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			hrdata_q <= 32'h00000000;
		end else begin
			hresp_q <= 1'b0;
			wr_pend_q <= accept & hwrite;
			rd_pend_q <= accept & ~hwrite;
			if (accept) begin
				addr_q <= haddr[7:0];
			end
			if (accept & ~hwrite) begin
				hreadyout_q <= 1'b0;
			end else begin
				hreadyout_q <= 1'b1;
			end
			if (rd_pend_q) begin
				hrdata_q <= rdata_d;
			end
		end
	end

	// ****************************************
	// read multiplexer
	// ****************************************
	// trigger registers are write only and read zero
	always @* begin
		rdata_d = 32'h00000000;
		if (addr_q == `OFS_PRESCALE) begin
			rdata_d[7:0] = presc_q;
		end
		if (addr_q == `OFS_STATUS) begin
			for (k = 0; k < NUM_CH; k = k + 1) begin
				rdata_d[`STS_RUN_LO + k] = run[k];
				rdata_d[`STS_RUN_HI_LO + k] = run_hi[k];
				rdata_d[`STS_BAD_LO + k] = bad[k];
				rdata_d[`STS_PIN_LO + k] = pin_lvl_q[k];
			end
		end
		for (k = 0; k < NUM_CH; k = k + 1) begin
			if (addr_q == `OFS_MODE_BASE + {k[5:0], 2'b00}) begin
				rdata_d[15:0] = mode_q[k];
			end
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_q <= `PRESCALE_RST;
			for (j = 0; j < NUM_CH; j = j + 1) begin
				mode_q[j] <= `MODE_RST;
			end
		end else begin
			if (commit & (addr_q == `OFS_PRESCALE)) begin
				presc_q <= hwdata[7:0];
			end
			for (j = 0; j < NUM_CH; j = j + 1) begin
				if (commit & (addr_q == `OFS_MODE_BASE + {j[5:0], 2'b00})) begin
					mode_q[j] <= hwdata[15:0] & `MODE_WMASK;
				end
			end
		end
	end

	// ****************************************
	// prescaler
	// ****************************************
	// one counter serves both outputs; a nibble change takes effect at once,
	// so the first divided pulse after a change may come early
	assign mask_a = (16'h0001 << presc_q[3:0]) - 16'h0001;
	assign mask_b = (16'h0001 << presc_q[7:4]) - 16'h0001;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_q <= {`PRESCALE_W{1'b0}};
			op_a_q <= 1'b0;
			op_b_q <= 1'b0;
		end else begin
			div_cnt_q <= div_cnt_q + 1'b1;
			op_a_q <= (div_cnt_q & mask_a[`PRESCALE_W-1:0]) == mask_a[`PRESCALE_W-1:0];
			op_b_q <= (div_cnt_q & mask_b[`PRESCALE_W-1:0]) == mask_b[`PRESCALE_W-1:0];
		end
	end

	assign op_clock_a = op_a_q;
	assign op_clock_b = op_b_q;

	// ****************************************
	// input pin synchronisers
	// ****************************************
	// a level is accepted only once stages two and three agree
	assign pin_lvl_d = (sync2_q & sync3_q) | (pin_lvl_q & (sync2_q ^ sync3_q));

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q <= {NUM_CH{1'b0}};
			sync2_q <= {NUM_CH{1'b0}};
			sync3_q <= {NUM_CH{1'b0}};
			pin_lvl_q <= {NUM_CH{1'b0}};
		end else begin
			sync1_q <= timer_input_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_lvl_q <= pin_lvl_d;
		end
	end

	// ****************************************
	// decoded mode fields for the datapath
	// ****************************************
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			halves_q <= {NUM_CH{1'b0}};
			func_q <= {(3*NUM_CH){1'b0}};
		end else begin
			for (m = 0; m < NUM_CH; m = m + 1) begin
				halves_q[m] <= ((m == 1) || (m == 3)) & mode_q[m][`SPLIT_BIT];
				func_q[3*m +: 3] <= mode_q[m][`FUNC_HI:`FUNC_LO];
			end
		end
	end

	assign eight_bit_halves = halves_q;
	assign channel_function_field = func_q;
	assign channel_running_flag = run;
	assign upper_running_flag = run_hi;

	// ****************************************
	// channels
	// ****************************************
	// the stop-all sequence before a clock source change is up to software
	genvar i;
	generate
		for (i = 0; i < NUM_CH; i = i + 1) begin : g_ch
			timer_channel #(
				.SPLIT_OK ((i == 1) || (i == 3))
			) u_ch (
				.hclk           (hclk),
				.hresetn        (hresetn),
				.mode           (mode_q[i]),
				.tick_a         (op_a_q),
				.tick_b         (op_b_q),
				.pin_level      (pin_lvl_q[i]),
				.sw_start       (wr_start & hwdata[i]),
				.sw_start_hi    (wr_start & hwdata[`START_HI_LO + i]),
				.stop           (wr_stop & hwdata[i]),
				.stop_hi        (wr_stop_hi & hwdata[i]),
				.master_irq     (master_channel_irq[i]),
				.count_tick_q   (channel_count_clock[i]),
				.start_trig_q   (start_trigger[i]),
				.capture_trig_q (capture_trigger[i]),
				.end_trig_q     (end_trigger[i]),
				.running_q      (run[i]),
				.running_hi_q   (run_hi[i]),
				.bad_q          (bad[i])
			);
		end
	endgenerate

endmodule // timer_setup

// *** verif/timer_setup_monitor.sv ***
// assertion checker bound to the timer setup block
`timescale 1ns/10ps
module timer_setup_monitor #(
	parameter NUM_CH = 4
) (
	input logic              hclk,
	input logic              hresetn,
	input logic              hsel,
	input logic [31:0]       haddr,
	input logic [1:0]        htrans,
	input logic              hwrite,
	input logic [31:0]       hwdata,
	input logic              hready,
	input logic              hreadyout,
	input logic              hresp,
	input logic              op_clock_a,
	input logic              op_clock_b,
	input logic [NUM_CH-1:0] channel_count_clock,
	input logic [NUM_CH-1:0] start_trigger,
	input logic [NUM_CH-1:0] end_trigger,
	input logic [NUM_CH-1:0] channel_running_flag,
	input logic [NUM_CH-1:0] eight_bit_halves,
	input logic [3*NUM_CH-1:0] channel_function_field
);
	// ****
	// write shadow and pulse gap counters
	// ****
	logic       wr_q;
	logic [7:0] ad_q;
	logic [7:0] pre_q;
	logic [7:0] age_q;
	logic [7:0] ga_q;
	logic [7:0] gb_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'h0;
			ad_q <= 8'h0;
			pre_q <= 8'h0;
			age_q <= 8'h0;
			ga_q <= 8'h0;
			gb_q <= 8'h0;
		end else begin
			wr_q <= hsel & htrans[1] & hready & hwrite;
			ad_q <= haddr[7:0];
			if (wr_q && ad_q == 8'h0)
				pre_q <= hwdata[7:0];
			// first pulse after a change may be early, so wait before judging gaps
			if (wr_q && ad_q == 8'h0)
				age_q <= 8'h0;
			else if (age_q != 8'hff)
				age_q <= age_q + 8'h1;
			ga_q <= op_clock_a ? 8'h1 : ga_q + 8'h1;
			gb_q <= op_clock_b ? 8'h1 : gb_q + 8'h1;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite
		|=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite
		|=> hreadyout) else $error("write stalled");
	clk_a_gap_a: assert property (op_clock_a && age_q > 8'h28 && pre_q[3:0] <= 4'h4
		|-> ga_q == (8'h1 << pre_q[3:0])) else $error("op clock a period");
	clk_b_gap_a: assert property (op_clock_b && age_q > 8'h28 && pre_q[7:4] <= 4'h4
		|-> gb_q == (8'h1 << pre_q[7:4])) else $error("op clock b period");
	split_odd_only_a: assert property (!eight_bit_halves[0] && !eight_bit_halves[2])
		else $error("split on even channel");
	tick_running_a: assert property ((channel_count_clock & ~(channel_running_flag
		| $past(channel_running_flag))) == '0) else $error("tick while stopped");
	func_follow_a: assert property (wr_q && ad_q == 8'h20
		|-> ##2 channel_function_field[2:0] == $past(hwdata[3:1], 2))
		else $error("function field");
	stop_clears_a: assert property (wr_q && ad_q == 8'h04 && hwdata[0]
		|-> ##[1:2] !channel_running_flag[0]) else $error("stop ignored");
	start_pulse_a: assert property (start_trigger[0] |=> !start_trigger[0])
		else $error("start pulse too long");
	cover property ($rose(channel_running_flag[0]));
	cover property (wr_q && ad_q == 8'h04 && hwdata[0]);
	cover property (end_trigger[0]);
endmodule // timer_setup_monitor

// *** verif/timer_setup_tb_top.sv ***
// self-checking testbench of the timer setup block
`timescale 1ns/10ps
module timer_setup_tb_top;
	// ****
	// stimulus and checks
	// ****
	logic        hclk = 0;
	logic        hresetn = 0;
	logic        hsel = 0;
	logic        hwrite = 0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [1:0]  htrans = '0;
	logic [2:0]  hsize = 3'h2;
	logic [3:0]  pin = '0;
	logic [3:0]  irq = '0;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, op_clock_a, op_clock_b;
	wire  [3:0]  cnt, st, cp, en, run, urun, half;
	wire  [11:0] fn;
	int          n_fail = 0, cmp_count = 0;
	int          n_a = 0, n_b = 0, n_t = 0, n_s = 0, n_c = 0, n_e = 0;
	int          a0, b0, t0, s0, c0, e0;
	logic [23:0] tab [11] = '{24'h000001, 24'h014051, 24'h010051, 24'h0200a1,
		24'h078003, 24'h040840, 24'h064c44, 24'h06cc44, 24'h018051, 24'h000203,
		24'h040001};
	logic [7:0]  pre [3] = '{8'h10, 8'h42, 8'h03};
	timer_setup #(.NUM_CH(4)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.timer_input_pin(pin), .master_channel_irq(irq), .op_clock_a, .op_clock_b,
		.channel_count_clock(cnt), .start_trigger(st), .capture_trigger(cp),
		.end_trigger(en), .channel_running_flag(run), .upper_running_flag(urun),
		.eight_bit_halves(half), .channel_function_field(fn));
	always #25 hclk = ~hclk;
	// counting on the falling edge keeps snapshots free of races
	always @(negedge hclk) begin
		n_a += op_clock_a;
		n_b += op_clock_b;
		n_t += cnt[0];
		n_s += st[0];
		n_c += cp[0];
		n_e += en[0];
	end
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_fail++;
			finish_test;
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask
	task snap;
		a0 = n_a;
		b0 = n_b;
		t0 = n_t;
		s0 = n_s;
		c0 = n_c;
		e0 = n_e;
	endtask
	task pulse;
		pin[0] <= 1;
		repeat (8) @(posedge hclk);
		pin[0] <= 0;
		repeat (8) @(posedge hclk);
	endtask
	task win(input logic [31:0] exp);
		repeat (8) @(posedge hclk);
		snap;
		repeat (32) @(posedge hclk);
		check("ticks", n_t - t0, exp);
	endtask
	task t_regs;
		bus(0, 8'h00, 0);
		check("presc rst", rd, 32'h0);
		bus(1, 8'h40, 32'hffffffff);
		bus(0, 8'h40, 0);
		check("unmapped", rd, 32'h0);
		bus(1, 8'h20, 32'hffffffff);
		bus(0, 8'h20, 0);
		check("mode mask", rd, 32'h9fcf);
		$display("test regs done");
	endtask
	task t_presc;
		foreach (pre[i]) begin
			bus(1, 8'h00, pre[i]);
			bus(0, 8'h00, 0);
			check("presc", rd, pre[i]);
			repeat (40) @(posedge hclk);
			snap;
			repeat (64) @(posedge hclk);
			check("clk a", n_a - a0, 64 >> pre[i][3:0]);
			check("clk b", n_b - b0, 64 >> pre[i][7:4]);
		end
		$display("test prescaler done");
	endtask
	task t_clk;
		bus(1, 8'h00, 8'h30);
		bus(1, 8'h20, 16'h0000);
		bus(1, 8'h0c, 32'h1);
		bus(0, 8'h10, 0);
		check("running", rd[0], 1'h1);
		win(32);
		bus(1, 8'h20, 16'h8000);
		win(4);
		bus(1, 8'h20, 16'h1040);
		repeat (8) @(posedge hclk);
		snap;
		repeat (3) pulse;
		check("pin ticks", n_t - t0, 3);
		bus(1, 8'h04, 32'h1);
		bus(1, 8'h20, 16'h0000);
		check("stopped", run[0], 1'h0);
		win(0);
		$display("test clock choice done");
	endtask
	task t_trig;
		bus(1, 8'h0c, 32'h1);
		foreach (tab[i]) begin
			bus(1, 8'h20, tab[i][23:8]);
			repeat (8) @(posedge hclk);
			snap;
			irq[0] <= 1;
			@(posedge hclk);
			irq[0] <= 0;
			repeat (8) @(posedge hclk);
			pulse;
			check("start", n_s - s0, tab[i][7:6]);
			if (tab[i][0])
				check("capture", n_c - c0, tab[i][5:4]);
			check("end", n_e - e0, tab[i][3:2]);
			bus(0, 8'h10, 0);
			check("bad", rd[16], tab[i][1]);
		end
		$display("test triggers done");
	endtask
	task t_split;
		bus(1, 8'h20, 16'h0000);
		bus(1, 8'h24, 16'h0804);
		bus(1, 8'h28, 16'h0006);
		bus(1, 8'h2c, 16'h000c);
		bus(1, 8'h0c, 32'h20);
		repeat (3) @(posedge hclk);
		check("halves", half, 4'h2);
		check("fields", fn, 12'hcd0);
		check("upper run", urun[1], 1'h1);
		// halt everything as before a system clock source change
		bus(1, 8'h04, 32'hf);
		bus(1, 8'h08, 32'ha);
		repeat (3) @(posedge hclk);
		check("all stop", {urun, run}, 8'h0);
		$display("test split done");
	endtask
	task finish_test;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		t_regs;
		t_presc;
		t_clk;
		t_trig;
		t_split;
		finish_test;
	end
	initial begin
		repeat (8000) @(posedge hclk);
		n_fail++;
		finish_test;
	end
endmodule // timer_setup_tb_top
bind timer_setup timer_setup_monitor #(.NUM_CH(NUM_CH)) mon (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .op_clock_a,
	.op_clock_b, .channel_count_clock, .start_trigger, .end_trigger,
	.channel_running_flag, .eight_bit_halves, .channel_function_field);
